// ===== shared/fsv_pkg.sv
// Purpose : Shared constants for the five-source vectored interrupt controller
// Assumes : 7-bit data memory address, 8-bit data, 8-bit vector addresses
// Notes   : Source index order is also the service priority, index 0 highest
`default_nettype none
package fsv_pkg;

  // ------------------------------------------------------------------
  // Data memory map
  // ------------------------------------------------------------------
  localparam int unsigned DM_ADDR_W = 7;
  localparam logic [6:0] ADDR_CTRL_PRIMARY   = 7'h0b;
  localparam logic [6:0] ADDR_CTRL_SECONDARY = 7'h1e;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int unsigned PRI_GLOBAL_EN_BIT = 0;
  localparam int unsigned PRI_EXT0_EN_BIT   = 1;
  localparam int unsigned PRI_EXT1_EN_BIT   = 2;
  localparam int unsigned PRI_TIMER_EN_BIT  = 3;
  localparam int unsigned PRI_EXT0_FLAG_BIT = 4;
  localparam int unsigned PRI_EXT1_FLAG_BIT = 5;
  localparam int unsigned PRI_TIMER_FLAG_BIT = 6;
  localparam int unsigned SEC_TB_EN_BIT     = 0;
  localparam int unsigned SEC_RTC_EN_BIT    = 1;
  localparam int unsigned SEC_TB_FLAG_BIT   = 4;
  localparam int unsigned SEC_RTC_FLAG_BIT  = 5;

  // ------------------------------------------------------------------
  // Sources, in priority order
  // ------------------------------------------------------------------
  localparam int unsigned NUM_SRC   = 5;
  localparam int unsigned SRC_EXT0  = 0;
  localparam int unsigned SRC_EXT1  = 1;
  localparam int unsigned SRC_TIMER = 2;
  localparam int unsigned SRC_TB    = 3;
  localparam int unsigned SRC_RTC   = 4;

  localparam logic [7:0] VEC_EXT0  = 8'h04;
  localparam logic [7:0] VEC_EXT1  = 8'h08;
  localparam logic [7:0] VEC_TIMER = 8'h0c;
  localparam logic [7:0] VEC_TB    = 8'h10;
  localparam logic [7:0] VEC_RTC   = 8'h14;

  // ------------------------------------------------------------------
  // Reset values and sizes
  // ------------------------------------------------------------------
  localparam logic [4:0] RST_FLAGS     = 5'h00;
  localparam logic [4:0] RST_ENABLES   = 5'h00;
  localparam logic       RST_GLOBAL_EN = 1'b0;
  localparam logic [7:0] RST_VECTOR    = 8'h00;
  localparam logic       RST_PIN_LEVEL = 1'b1;
  localparam int unsigned STACK_LEVELS = 4;
  localparam int unsigned STACK_PTR_W  = 3;
  localparam int unsigned SYNC_STAGES  = 2;

endpackage : fsv_pkg
`default_nettype wire

// ===== hdl/fsv_pin_fall.sv
// Purpose : Synchronise external request pins and detect falling edges
// Assumes : Pins are asynchronous to clk_sys_i and idle high
// Notes   : Edge is taken between second and third stage only
`timescale 1ns/1ps
`default_nettype none
module fsv_pin_fall
  import fsv_pkg::*;
#(
  parameter int unsigned NUM_PINS = 2
) (
  input  wire logic                clk_sys_i,
  input  wire logic                reset_i,
  input  wire logic [NUM_PINS-1:0] pin_i,
  output logic      [NUM_PINS-1:0] fall_o
);

  // ------------------------------------------------------------------
  // Per-pin synchroniser and edge detector
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1) begin : g_pin
      logic meta_reg;
      logic sync_reg;
      logic last_reg;
      // Only sync_reg reads meta_reg
      always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
          meta_reg <= RST_PIN_LEVEL;
          sync_reg <= RST_PIN_LEVEL;
          last_reg <= RST_PIN_LEVEL;
        end else begin
          meta_reg <= pin_i[g];
          sync_reg <= meta_reg;
          last_reg <= sync_reg;
        end
      end
      assign fall_o[g] = last_reg & ~sync_reg;
    end
  endgenerate

endmodule : fsv_pin_fall
`default_nettype wire

// ===== hdl/fsv_irq_ctrl.sv
// Purpose : Five-source vectored interrupt controller with two control registers
// Assumes : Core gives a phase pulse at each instruction boundary and its stack depth
// Notes   : Vector and acknowledge appear one cycle after the accepting phase pulse
//
// Notes on behaviour
// - Falling edge on external pin 0 or 1 sets flag bit 4 or 5 of primary.
// - Enabled flagged external request with free stack calls vector 04H or 08H.
// - Acknowledge clears the served request flag and the global enable bit.
// - Timer overflow sets primary bit 6; served through vector 0CH when allowed.
// - Time-base tick sets secondary bit 4; served through vector 10H when allowed.
// - Clock tick sets secondary bit 5; served through vector 14H when allowed.
// - No acknowledge while stack full; request stays pending until depth drops.
// - Requests during a blocked service routine still set their flags.
// - Software re-enabling inside a routine permits nested acknowledge if stack free.
// - Acknowledge only pushes the program counter then branches to the vector.
// - Interrupt return sets global enable; plain return leaves it unchanged.
// - Requests between two phase pulses are evaluated at the later pulse.
// - Simultaneous requests served: ext0, ext1, timer, time base, clock tick.
// - A request flag stays set until serviced or cleared by software.
// - Any of the five sources can wake the halted device.
// - Primary holds global, ext0, ext1, timer enables at bits 0-3; bit 7 zero.
// - Secondary holds time-base and clock enables at bits 0,1 and their flags at bits 4,5; others read zero.
// - Primary sits at data address 0BH, secondary at 1EH, as ordinary data.
// - Service needs both global enable and own enable; otherwise stays pending.
// - The return stack holds four entries; full means all four used.
`timescale 1ns/1ps
`default_nettype none
module fsv_irq_ctrl
  import fsv_pkg::*;
#(
  parameter int unsigned STACK_DEPTH = STACK_LEVELS
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_i,
  input  wire logic                   ext_irq_pin_zero_i,
  input  wire logic                   ext_irq_pin_one_i,
  input  wire logic                   timer_overflow_i,
  input  wire logic                   timebase_tick_i,
  input  wire logic                   clock_tick_i,
  input  wire logic                   second_clock_phase_i,
  input  wire logic [STACK_PTR_W-1:0] stack_depth_pointer_i,
  input  wire logic                   return_and_enable_instr_i,
  input  wire logic                   return_plain_instr_i,
  input  wire logic [DM_ADDR_W-1:0]   dm_addr_i,
  input  wire logic                   dm_wr_i,
  input  wire logic [7:0]             dm_wdata_i,
  output logic      [7:0]             dm_rdata_o,
  output logic                        dm_hit_o,
  output logic                        irq_ack_o,
  output logic      [7:0]             irq_vector_o,
  output logic                        wake_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [NUM_SRC-1:0] flag_reg;
  logic [NUM_SRC-1:0] flag_next;
  logic [NUM_SRC-1:0] enable_reg;
  logic               global_irq_enable_reg;
  logic               ack_reg;
  logic [7:0]         vector_reg;
  logic [7:0]         rdata_reg;
  logic               hit_reg;
  logic               wake_reg;

  logic [1:0]         pin_fall;
  logic [NUM_SRC-1:0] event_set;
  logic               wr_primary;
  logic               wr_secondary;
  logic [NUM_SRC-1:0] sw_flag_wr;
  logic [NUM_SRC-1:0] sw_flag_val;
  logic [NUM_SRC-1:0] pending;
  logic [NUM_SRC-1:0] grant;
  logic [NUM_SRC-1:0] flag_clr;
  logic               stack_full;
  logic               do_ack;
  logic [7:0]         grant_vector;

  // Named fields for reading
  logic ext0_request_flag;
  logic ext1_request_flag;
  logic timer_request_flag;
  logic timebase_request_flag;
  logic clock_tick_request_flag;
  logic ext0_irq_enable;
  logic ext1_irq_enable;
  logic timer_irq_enable;
  logic timebase_irq_enable;
  logic clock_tick_irq_enable;
  logic [7:0] irq_control_primary;
  logic [7:0] irq_control_secondary;

  // ------------------------------------------------------------------
  // Event sources
  // ------------------------------------------------------------------
  fsv_pin_fall #(
    .NUM_PINS (2)
  ) u_pin_fall (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .pin_i     ({ext_irq_pin_one_i, ext_irq_pin_zero_i}),
    .fall_o    (pin_fall)
  );

  // Index order equals priority order
  assign event_set = {clock_tick_i, timebase_tick_i, timer_overflow_i,
                      pin_fall[1], pin_fall[0]};

  // ------------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------------
  assign wr_primary   = dm_wr_i && (dm_addr_i == ADDR_CTRL_PRIMARY);
  assign wr_secondary = dm_wr_i && (dm_addr_i == ADDR_CTRL_SECONDARY);

  assign sw_flag_wr  = {wr_secondary, wr_secondary, wr_primary, wr_primary, wr_primary};
  assign sw_flag_val = {dm_wdata_i[SEC_RTC_FLAG_BIT],   dm_wdata_i[SEC_TB_FLAG_BIT],
                        dm_wdata_i[PRI_TIMER_FLAG_BIT], dm_wdata_i[PRI_EXT1_FLAG_BIT],
                        dm_wdata_i[PRI_EXT0_FLAG_BIT]};

  // ------------------------------------------------------------------
  // Arbitration
  // ------------------------------------------------------------------
  // Depth counts occupied entries; stack is full at all four in use
  assign stack_full = ({29'h0, stack_depth_pointer_i} >= STACK_DEPTH);
  assign pending    = flag_reg & enable_reg & {NUM_SRC{global_irq_enable_reg}};

  // Fixed priority: lowest index wins
  always_comb begin
    grant = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        grant = '0;
        grant[i] = 1'b1;
      end
    end
  end

  always_comb begin
    case (grant)
      5'h01:   grant_vector = VEC_EXT0;
      5'h02:   grant_vector = VEC_EXT1;
      5'h04:   grant_vector = VEC_TIMER;
      5'h08:   grant_vector = VEC_TB;
      5'h10:   grant_vector = VEC_RTC;
      default: grant_vector = RST_VECTOR;
    endcase
  end

  // Only at a phase pulse, so a request seen mid-instruction waits for the next one
  assign do_ack   = second_clock_phase_i && (|pending) && !stack_full;
  assign flag_clr = grant & {NUM_SRC{do_ack}};

  // ------------------------------------------------------------------
  // Request flags
  // ------------------------------------------------------------------
  // A new event beats both the acknowledge clear and a software write,
  // so an edge landing on the clearing cycle is never lost.
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g = g + 1) begin : g_flag
      always_comb begin
        if (event_set[g]) begin
          flag_next[g] = 1'b1;
        end else if (flag_clr[g]) begin
          flag_next[g] = 1'b0;
        end else if (sw_flag_wr[g]) begin
          flag_next[g] = sw_flag_val[g];
        end else begin
          flag_next[g] = flag_reg[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      flag_reg <= RST_FLAGS;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ------------------------------------------------------------------
  // Enables
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      enable_reg <= RST_ENABLES;
    end else begin
      if (wr_primary) begin
        enable_reg[SRC_EXT0]  <= dm_wdata_i[PRI_EXT0_EN_BIT];
        enable_reg[SRC_EXT1]  <= dm_wdata_i[PRI_EXT1_EN_BIT];
        enable_reg[SRC_TIMER] <= dm_wdata_i[PRI_TIMER_EN_BIT];
      end
      if (wr_secondary) begin
        enable_reg[SRC_TB]  <= dm_wdata_i[SEC_TB_EN_BIT];
        enable_reg[SRC_RTC] <= dm_wdata_i[SEC_RTC_EN_BIT];
      end
    end
  end

  // Acknowledge beats a same-cycle software write so a routine always starts blocked
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      global_irq_enable_reg <= RST_GLOBAL_EN;
    end else if (do_ack) begin
      global_irq_enable_reg <= 1'b0;
    end else if (return_and_enable_instr_i) begin
      global_irq_enable_reg <= 1'b1;
    end else if (wr_primary) begin
      global_irq_enable_reg <= dm_wdata_i[PRI_GLOBAL_EN_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Core handshake
  // ------------------------------------------------------------------
  // One pulse per acceptance; the core pushes the PC only, nothing else
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ack_reg    <= 1'b0;
      vector_reg <= RST_VECTOR;
    end else begin
      ack_reg <= do_ack;
      if (do_ack) begin
        vector_reg <= grant_vector;
      end
    end
  end

  // Wake on any latched flag, enabled or not
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= |flag_reg;
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  assign ext0_request_flag       = flag_reg[SRC_EXT0];
  assign ext1_request_flag       = flag_reg[SRC_EXT1];
  assign timer_request_flag      = flag_reg[SRC_TIMER];
  assign timebase_request_flag   = flag_reg[SRC_TB];
  assign clock_tick_request_flag = flag_reg[SRC_RTC];
  assign ext0_irq_enable         = enable_reg[SRC_EXT0];
  assign ext1_irq_enable         = enable_reg[SRC_EXT1];
  assign timer_irq_enable        = enable_reg[SRC_TIMER];
  assign timebase_irq_enable     = enable_reg[SRC_TB];
  assign clock_tick_irq_enable   = enable_reg[SRC_RTC];

  // Unused bits read as zero
  assign irq_control_primary   = {1'b0, timer_request_flag, ext1_request_flag,
                                  ext0_request_flag, timer_irq_enable, ext1_irq_enable,
                                  ext0_irq_enable, global_irq_enable_reg};
  assign irq_control_secondary = {2'b00, clock_tick_request_flag, timebase_request_flag,
                                  2'b00, clock_tick_irq_enable, timebase_irq_enable};

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_reg <= 8'h00;
      hit_reg   <= 1'b0;
    end else begin
      case (dm_addr_i)
        ADDR_CTRL_PRIMARY: begin
          rdata_reg <= irq_control_primary;
          hit_reg   <= 1'b1;
        end
        ADDR_CTRL_SECONDARY: begin
          rdata_reg <= irq_control_secondary;
          hit_reg   <= 1'b1;
        end
        default: begin
          rdata_reg <= 8'h00;
          hit_reg   <= 1'b0;
        end
      endcase
    end
  end

  assign dm_rdata_o   = rdata_reg;
  assign dm_hit_o     = hit_reg;
  assign irq_ack_o    = ack_reg;
  assign irq_vector_o = vector_reg;
  assign wake_o       = wake_reg;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_ext0_fall;
    $fell(u_pin_fall.g_pin[0].sync_reg);
  endsequence

  sequence s_ack_out;
    ack_reg ##1 !ack_reg;
  endsequence

  a_ext_edge_flag: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_ext0_fall |=> flag_reg[SRC_EXT0])
    else $error("ext0 falling edge did not set its flag");

  a_ext1_vector: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (ack_reg && vector_reg == VEC_EXT1) |-> $past(flag_reg[SRC_EXT1] && enable_reg[SRC_EXT1]))
    else $error("ext1 vector without enabled ext1 flag");

  a_ack_blocks_all: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ack_reg |-> (!global_irq_enable_reg &&
                 ((flag_reg & $past(grant)) == ($past(event_set) & $past(grant)))))
    else $error("acknowledge left global enable or served flag set");

  a_timer_flag: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    timer_overflow_i |=> flag_reg[SRC_TIMER])
    else $error("timer overflow did not set its flag");

  a_timebase_flag: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    timebase_tick_i |=> irq_control_secondary[SEC_TB_FLAG_BIT])
    else $error("time-base tick did not set its flag");

  a_clock_flag: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    clock_tick_i |=> irq_control_secondary[SEC_RTC_FLAG_BIT])
    else $error("clock tick did not set its flag");

  a_full_stack_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ack_reg |-> ($past(stack_depth_pointer_i) < STACK_DEPTH))
    else $error("acknowledge taken with four stack entries used");

  a_enable_gate: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ack_reg |-> $past(global_irq_enable_reg && |(flag_reg & enable_reg)))
    else $error("acknowledge without both enables");

  a_single_vector: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ack_reg |-> s_ack_out)
    else $error("acknowledge longer than one cycle");

  a_phase_ack: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ack_reg |-> $past(second_clock_phase_i))
    else $error("acknowledge away from a phase pulse");

  a_ext0_first: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (ack_reg && vector_reg != VEC_EXT0) |-> !$past(pending[SRC_EXT0]))
    else $error("lower source served before pending ext0");

  a_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (flag_reg[SRC_TB] && !flag_clr[SRC_TB] && !sw_flag_wr[SRC_TB]) |=> flag_reg[SRC_TB])
    else $error("time-base flag dropped without service or write");

  a_return_enable: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (return_and_enable_instr_i && !do_ack) |=> global_irq_enable_reg)
    else $error("interrupt return did not set global enable");

  a_plain_return: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (return_plain_instr_i && !return_and_enable_instr_i && !do_ack && !wr_primary)
      |=> $stable(global_irq_enable_reg))
    else $error("plain return changed global enable");

  a_wake_any: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (|flag_reg) |=> wake_o)
    else $error("pending flag did not raise wake");

endmodule : fsv_irq_ctrl
`default_nettype wire

// ===== verif/fsv_core_model.sv
// Purpose : Core sequencer stand-in: instruction phase pulses and return stack depth
// Assumes : One phase pulse every four system clocks
// Notes   : Depth saturates at four; a call on a full stack is not counted
`timescale 1ns/1ps
`default_nettype none
module fsv_core_model
  import fsv_pkg::*;
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_i,
  input  wire logic                   irq_ack_i,
  input  wire logic                   call_i,
  input  wire logic                   ret_i,
  output logic                        phase_o,
  output logic      [STACK_PTR_W-1:0] depth_o
);
  logic [1:0] div_reg;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) div_reg <= 2'h0;
    else div_reg <= div_reg + 2'h1;
  end
  assign phase_o = (div_reg == 2'h3);
  // Only the return address is pushed, so depth is the whole stack state
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) depth_o <= '0;
    else if ((irq_ack_i | call_i) && !ret_i && depth_o < 3'(STACK_LEVELS))
      depth_o <= depth_o + 3'h1;
    else if (ret_i && !(irq_ack_i | call_i) && depth_o != 3'h0) depth_o <= depth_o - 3'h1;
  end
endmodule : fsv_core_model
`default_nettype wire

// ===== verif/tb_top.sv
// Purpose : Self-checking bench for the vectored interrupt controller
// Assumes : Core model supplies phase pulses and stack depth
// Notes   : Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
  import fsv_pkg::*;
;
  typedef struct {logic [7:0] pri; logic [7:0] sec; int src; logic [7:0] vec;} fsv_row_t;
  logic clk = 1'b0, rst = 1'b1, pin0 = 1'b1, pin1 = 1'b1, tmr = 1'b0, tbk = 1'b0, rtk = 1'b0;
  logic return_and_enable_instr = 1'b0, rplain = 1'b0, call = 1'b0, wr = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic phase, hit, ack, wake;
  logic [2:0] depth;
  logic [7:0] rdata, vec;
  int err_total = 0, samples_checked = 0;
  fsv_row_t rows [5];
  always #2.5 clk = ~clk;
  fsv_core_model u_fsv_core_model (.clk_sys_i(clk), .reset_i(rst), .irq_ack_i(ack),
    .call_i(call), .ret_i(return_and_enable_instr | rplain), .phase_o(phase), .depth_o(depth));
  fsv_irq_ctrl u_fsv_irq_ctrl (.clk_sys_i(clk), .reset_i(rst), .ext_irq_pin_zero_i(pin0),
    .ext_irq_pin_one_i(pin1), .timer_overflow_i(tmr), .timebase_tick_i(tbk),
    .clock_tick_i(rtk), .second_clock_phase_i(phase), .stack_depth_pointer_i(depth),
    .return_and_enable_instr_i(return_and_enable_instr), .return_plain_instr_i(rplain), .dm_addr_i(addr),
    .dm_wr_i(wr), .dm_wdata_i(wdata), .dm_rdata_o(rdata), .dm_hit_o(hit),
    .irq_ack_o(ack), .irq_vector_o(vec), .wake_o(wake));
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  task automatic wrr(input logic [6:0] a, input logic [7:0] d);
    step(); addr = a; wr = 1'b1; wdata = d;
    step(); wr = 1'b0;
  endtask : wrr
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic h);
    step(); addr = a;
    step();
    `CHK(rdata, e)
    `CHK(hit, h)
  endtask : rd
  task automatic fire(input int s);
    step();
    case (s)
      0: pin0 = 1'b0;
      1: pin1 = 1'b0;
      2: tmr = 1'b1;
      3: tbk = 1'b1;
      default: rtk = 1'b1;
    endcase
    step(); {pin0, pin1, tmr, tbk, rtk} = 5'h18;
  endtask : fire
  task automatic ret(input logic en);
    step(); return_and_enable_instr = en; rplain = ~en;
    step(); return_and_enable_instr = 1'b0; rplain = 1'b0;
  endtask : ret
  task automatic wack(input logic [7:0] v);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 40 && !seen; i++) begin
      step(); seen = (ack === 1'b1);
    end
    `CHK(seen, 1'b1)
    `CHK(vec, v)
  endtask : wack
  task automatic nack(input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      step(); if (ack !== 1'b0) bad = 1'b1;
    end
    `CHK(bad, 1'b0)
  endtask : nack
  task automatic results();
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    #(5 * 20000);
    err_total++;
    results();
  end
  initial begin
    rows = '{'{8'h03, 8'h00, 0, VEC_EXT0}, '{8'h05, 8'h00, 1, VEC_EXT1},
             '{8'h09, 8'h00, 2, VEC_TIMER}, '{8'h01, 8'h01, 3, VEC_TB},
             '{8'h01, 8'h02, 4, VEC_RTC}};
    repeat (16) step();
    rst = 1'b0;
    foreach (rows[i]) begin
      wrr(ADDR_CTRL_PRIMARY, rows[i].pri);
      wrr(ADDR_CTRL_SECONDARY, rows[i].sec);
      fire(rows[i].src);
      wack(rows[i].vec);
      rd(ADDR_CTRL_PRIMARY, rows[i].pri & 8'h0e, 1'b1);
      rd(ADDR_CTRL_SECONDARY, rows[i].sec & 8'h03, 1'b1);
      ret(1'b1);
    end
    wrr(ADDR_CTRL_PRIMARY, 8'h80);
    rd(ADDR_CTRL_PRIMARY, 8'h00, 1'b1);
    wrr(ADDR_CTRL_SECONDARY, 8'hcc);
    rd(ADDR_CTRL_SECONDARY, 8'h00, 1'b1);
    rd(7'h0c, 8'h00, 1'b0);
    wrr(ADDR_CTRL_PRIMARY, 8'h01);
    fire(2);
    nack(16);
    `CHK(wake, 1'b1)
    rd(ADDR_CTRL_PRIMARY, 8'h41, 1'b1);
    wrr(ADDR_CTRL_PRIMARY, 8'h00);
    rd(ADDR_CTRL_PRIMARY, 8'h00, 1'b1);
    // All five pending at once with global off, then released one by one
    wrr(ADDR_CTRL_SECONDARY, 8'h33);
    wrr(ADDR_CTRL_PRIMARY, 8'h7e);
    nack(16);
    ret(1'b0);
    nack(16);
    foreach (rows[i]) begin
      ret(1'b1);
      wack(rows[i].vec);
    end
    repeat (3) begin
      step(); call = 1'b1;
      step(); call = 1'b0;
    end
    wrr(ADDR_CTRL_PRIMARY, 8'h03);
    fire(0);
    nack(20);
    ret(1'b0);
    wack(VEC_EXT0);
    ret(1'b0);
    fire(3);
    nack(12);
    wrr(ADDR_CTRL_PRIMARY, 8'h03);
    wack(VEC_TB);
    step(); rst = 1'b1;
    repeat (4) step();
    rst = 1'b0;
    rd(ADDR_CTRL_PRIMARY, 8'h00, 1'b1);
    rd(ADDR_CTRL_SECONDARY, 8'h00, 1'b1);
    `CHK(wake, 1'b0)
    results();
  end
endmodule : tb_top
`default_nettype wire
